//--- rtl/aic_cfg.svh
`ifndef AIC_CFG_SVH
`define AIC_CFG_SVH

// Register offsets
`define AIC_OFF_ROUTE2 8'h1B
`define AIC_OFF_SRC 8'h1E
`define AIC_OFF_PINCFG 8'h20
`define AIC_OFF_HOLD 8'h21
`define AIC_OFF_LOWDLY 8'h22
`define AIC_OFF_LOWTH 8'h23
`define AIC_OFF_HYST 8'h24
`define AIC_OFF_HIGHDLY 8'h25
`define AIC_OFF_STATUS 8'h0B

// Reset values
`define AIC_RST_ROUTE2 8'h00
`define AIC_RST_SRC 8'h00
`define AIC_RST_PINCFG 8'h05
`define AIC_RST_HOLD 8'h00
`define AIC_RST_LOWDLY 8'h09
`define AIC_RST_LOWTH 8'h30
`define AIC_RST_HYST 8'h81
`define AIC_RST_HIGHDLY 8'h0F

// Implemented bits per register
`define AIC_MASK_SRC 8'h3F
`define AIC_MASK_PINCFG 8'h0F
`define AIC_MASK_HOLD 8'h0F
`define AIC_MASK_HYST 8'hC7

// Field positions
`define AIC_BIT_P1_POL 0
`define AIC_BIT_P1_OD 1
`define AIC_BIT_P2_POL 2
`define AIC_BIT_P2_OD 3
`define AIC_BIT_CLEAR 7
`define AIC_BIT_LOW_MODE 2
`define AIC_LSB_STRONG_ACCEL_HYSTERESIS 6
`define AIC_LSB_WEAK_ACCEL_HYSTERESIS 0

// Engine bit order in routing and status
`define AIC_ENG_LOW 0
`define AIC_ENG_HIGH 1
`define AIC_ENG_COUNT 8

// Scaling steps
`define AIC_LOWTH_STEP_CMG 18'h0030D
`define AIC_LOWHY_STEP_MG 12'h07D
`define AIC_HIGHHY_STEP_2G_MG 12'h07D
`define AIC_HIGHHY_STEP_4G_MG 12'h0FA
`define AIC_HIGHHY_STEP_8G_MG 12'h1F4
`define AIC_HIGHHY_STEP_16G_MG 12'h3E8

// Timing
`define AIC_CLK_HZ 50000000
`define AIC_BASE_TICK_NS 250000
`define AIC_BASE_TICK_CYC ((`AIC_BASE_TICK_NS / 1000) * (`AIC_CLK_HZ / 1000000))
`define AIC_DLY_TICK_NS 2000000
`define AIC_DLY_PER_BASE (`AIC_DLY_TICK_NS / `AIC_BASE_TICK_NS)

// Temporary hold lengths in base ticks of 250 us
`define AIC_HOLD_250US 16'h0001
`define AIC_HOLD_500US 16'h0002
`define AIC_HOLD_1MS 16'h0004
`define AIC_HOLD_12M5 16'h0032
`define AIC_HOLD_25MS 16'h0064
`define AIC_HOLD_50MS 16'h00C8
`define AIC_HOLD_250MS 16'h03E8
`define AIC_HOLD_500MS 16'h07D0
`define AIC_HOLD_1S 16'h0FA0
`define AIC_HOLD_2S 16'h1F40
`define AIC_HOLD_4S 16'h3E80
`define AIC_HOLD_8S 16'h7D00

`endif

//--- rtl/aic_pkg.sv
package aic_pkg;
    typedef enum logic [1:0] {
        AIC_HOLD_NONE = 2'b00,
        AIC_HOLD_TEMP = 2'b01,
        AIC_HOLD_LATCH = 2'b10
    } aic_hold_e;
    typedef logic [15:0] aic_ticks_t;
endpackage

//--- rtl/aic_persist.sv
`timescale 1ns/1ps
`default_nettype none
`include "aic_cfg.svh"

module aic_persist
    import aic_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic tick_in,
    input wire logic cond_in,
    input wire logic [7:0] dur_in,
    output logic trig_out
);
    logic [8:0] cnt;
    logic [8:0] need;

    // One extra tick covers the partial first period
    assign need = {1'b0, dur_in} + 9'h002;

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt <= 9'h000;
        end else if (!cond_in) begin
            cnt <= 9'h000;
        end else if (tick_in && cnt < need) begin
            cnt <= cnt + 9'h001;
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            trig_out <= 1'b0;
        end else begin
            trig_out <= cond_in && (cnt >= need);
        end
    end
endmodule

`default_nettype wire

//--- rtl/aic_top.sv
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "aic_cfg.svh"

module aic_top
    import aic_pkg::*;
#(
    parameter int BASE_TICK_CYC = `AIC_BASE_TICK_CYC
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [7:2] engine_event_in,
    input wire logic weak_accel_cond_in,
    input wire logic strong_accel_cond_in,
    input wire logic [7:0] first_pin_route_in,
    input wire logic [1:0] range_sel_in,
    output logic [5:0] engine_unfiltered_out,
    output logic [17:0] weak_accel_threshold_cmg_out,
    output logic [8:0] weak_accel_hysteresis_mg_out,
    output logic [11:0] strong_accel_hysteresis_mg_out,
    output logic weak_accel_sum_mode_out,
    output logic [7:0] engine_status_out,
    output logic first_irq_pin_out,
    output logic first_irq_pin_oe_n_out,
    output logic second_irq_pin_out,
    output logic second_irq_pin_oe_n_out
);
    localparam int NENG = `AIC_ENG_COUNT;

    logic [7:0] second_pin_route;
    logic [7:0] engine_source_select;
    logic [7:0] pin_electrical_config;
    logic [7:0] hold_mode_and_clear;
    logic [7:0] lowg_delay;
    logic [7:0] lowg_threshold;
    logic [7:0] lowg_highg_hysteresis;
    logic [7:0] highg_delay;

    logic wr_route2, wr_src, wr_pincfg, wr_hold;
    logic wr_lowdly, wr_lowth, wr_hyst, wr_highdly;
    logic clear_req;
    logic [7:0] next_rdata;

    logic [15:0] base_div;
    logic base_tick;
    logic [2:0] dly_div;
    logic dly_tick;

    logic weak_trig, strong_trig;
    logic [NENG-1:0] raw_evt;
    logic [NENG-1:0] held;
    aic_hold_e hold_kind;
    aic_ticks_t hold_len;
    logic first_active, second_active;

    // Classify the hold field
    function automatic aic_hold_e hold_class(input logic [3:0] code);
        if (code[2:0] == 3'h0) begin
            hold_class = AIC_HOLD_NONE;
        end else if (code[2:0] == 3'h7) begin
            hold_class = AIC_HOLD_LATCH;
        end else begin
            hold_class = AIC_HOLD_TEMP;
        end
    endfunction

    // Hold length in base ticks
    function automatic aic_ticks_t hold_ticks(input logic [3:0] code);
        unique case (code)
            4'h1: hold_ticks = `AIC_HOLD_250MS;
            4'h2: hold_ticks = `AIC_HOLD_500MS;
            4'h3: hold_ticks = `AIC_HOLD_1S;
            4'h4: hold_ticks = `AIC_HOLD_2S;
            4'h5: hold_ticks = `AIC_HOLD_4S;
            4'h6: hold_ticks = `AIC_HOLD_8S;
            4'h9: hold_ticks = `AIC_HOLD_250US;
            4'hA: hold_ticks = `AIC_HOLD_500US;
            4'hB: hold_ticks = `AIC_HOLD_1MS;
            4'hC: hold_ticks = `AIC_HOLD_12M5;
            4'hD: hold_ticks = `AIC_HOLD_25MS;
            4'hE: hold_ticks = `AIC_HOLD_50MS;
            default: hold_ticks = 16'h0000;
        endcase
    endfunction

    // Pin level for a given activity, polarity and drive
    function automatic logic [1:0] pin_drive(input logic act, input logic pol,
                                             input logic od);
        logic lvl;
        lvl = act ? pol : ~pol;
        if (od) begin
            pin_drive = {lvl, lvl};
        end else begin
            pin_drive = {1'b0, lvl};
        end
    endfunction

    assign wr_route2 = reg_wr_in && reg_addr_in == `AIC_OFF_ROUTE2;
    assign wr_src = reg_wr_in && reg_addr_in == `AIC_OFF_SRC;
    assign wr_pincfg = reg_wr_in && reg_addr_in == `AIC_OFF_PINCFG;
    assign wr_hold = reg_wr_in && reg_addr_in == `AIC_OFF_HOLD;
    assign wr_lowdly = reg_wr_in && reg_addr_in == `AIC_OFF_LOWDLY;
    assign wr_lowth = reg_wr_in && reg_addr_in == `AIC_OFF_LOWTH;
    assign wr_hyst = reg_wr_in && reg_addr_in == `AIC_OFF_HYST;
    assign wr_highdly = reg_wr_in && reg_addr_in == `AIC_OFF_HIGHDLY;
    assign clear_req = wr_hold && reg_wdata_in[`AIC_BIT_CLEAR];

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            second_pin_route <= `AIC_RST_ROUTE2;
        end else if (wr_route2) begin
            second_pin_route <= reg_wdata_in;
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            engine_source_select <= `AIC_RST_SRC;
        end else if (wr_src) begin
            engine_source_select <= reg_wdata_in & `AIC_MASK_SRC;
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pin_electrical_config <= `AIC_RST_PINCFG;
        end else if (wr_pincfg) begin
            pin_electrical_config <= reg_wdata_in & `AIC_MASK_PINCFG;
        end
    end

    // Clear bit is not stored
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            hold_mode_and_clear <= `AIC_RST_HOLD;
        end else if (wr_hold) begin
            hold_mode_and_clear <= reg_wdata_in & `AIC_MASK_HOLD;
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            lowg_delay <= `AIC_RST_LOWDLY;
            lowg_threshold <= `AIC_RST_LOWTH;
            lowg_highg_hysteresis <= `AIC_RST_HYST;
            highg_delay <= `AIC_RST_HIGHDLY;
        end else begin
            if (wr_lowdly) begin
                lowg_delay <= reg_wdata_in;
            end
            if (wr_lowth) begin
                lowg_threshold <= reg_wdata_in;
            end
            if (wr_hyst) begin
                lowg_highg_hysteresis <= reg_wdata_in & `AIC_MASK_HYST;
            end
            if (wr_highdly) begin
                highg_delay <= reg_wdata_in;
            end
        end
    end

    // Read mux, unmapped addresses read zero
    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                `AIC_OFF_ROUTE2: next_rdata = second_pin_route;
                `AIC_OFF_SRC: next_rdata = engine_source_select;
                `AIC_OFF_PINCFG: next_rdata = pin_electrical_config;
                `AIC_OFF_HOLD: next_rdata = hold_mode_and_clear;
                `AIC_OFF_LOWDLY: next_rdata = lowg_delay;
                `AIC_OFF_LOWTH: next_rdata = lowg_threshold;
                `AIC_OFF_HYST: next_rdata = lowg_highg_hysteresis;
                `AIC_OFF_HIGHDLY: next_rdata = highg_delay;
                `AIC_OFF_STATUS: next_rdata = held;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 8'h00;
        end else begin
            reg_rdata_out <= next_rdata;
        end
    end

    // 250 us base tick and 2 ms delay tick
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            base_div <= 16'h0000;
            base_tick <= 1'b0;
        end else if (base_div == 16'(BASE_TICK_CYC - 1)) begin
            base_div <= 16'h0000;
            base_tick <= 1'b1;
        end else begin
            base_div <= base_div + 16'h0001;
            base_tick <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            dly_div <= 3'h0;
            dly_tick <= 1'b0;
        end else begin
            dly_tick <= 1'b0;
            if (base_tick) begin
                if (dly_div == 3'(`AIC_DLY_PER_BASE - 1)) begin
                    dly_div <= 3'h0;
                    dly_tick <= 1'b1;
                end else begin
                    dly_div <= dly_div + 3'h1;
                end
            end
        end
    end

    aic_persist u_weak_persist (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .tick_in(dly_tick),
        .cond_in(weak_accel_cond_in),
        .dur_in(lowg_delay),
        .trig_out(weak_trig)
    );

    aic_persist u_strong_persist (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .tick_in(dly_tick),
        .cond_in(strong_accel_cond_in),
        .dur_in(highg_delay),
        .trig_out(strong_trig)
    );

    assign raw_evt = {engine_event_in, strong_trig, weak_trig};
    assign hold_kind = hold_class(hold_mode_and_clear[3:0]);
    assign hold_len = hold_ticks(hold_mode_and_clear[3:0]);

    // Per-engine hold state, a new event beats a clear
    genvar gi;
    generate
        for (gi = 0; gi < NENG; gi++) begin : g_eng
            logic latched;
            aic_ticks_t remain;

            always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    latched <= 1'b0;
                end else if (hold_kind == AIC_HOLD_LATCH && raw_evt[gi]) begin
                    latched <= 1'b1;
                end else if (clear_req || hold_kind != AIC_HOLD_LATCH) begin
                    latched <= 1'b0;
                end
            end

            // One extra tick so the hold never ends early
            always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    remain <= 16'h0000;
                end else if (hold_kind == AIC_HOLD_TEMP && raw_evt[gi]) begin
                    remain <= hold_len + 16'h0001;
                end else if (clear_req || hold_kind != AIC_HOLD_TEMP) begin
                    remain <= 16'h0000;
                end else if (base_tick && remain != 16'h0000) begin
                    remain <= remain - 16'h0001;
                end
            end

            assign held[gi] = raw_evt[gi] || latched || remain != 16'h0000;
        end
    endgenerate

    assign first_active = |(held & first_pin_route_in);
    assign second_active = |(held & second_pin_route);

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            engine_status_out <= 8'h00;
        end else begin
            engine_status_out <= held;
        end
    end

    // Open-drain only pulls low, otherwise releases
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            first_irq_pin_out <= 1'b0;
            first_irq_pin_oe_n_out <= 1'b0;
            second_irq_pin_out <= 1'b0;
            second_irq_pin_oe_n_out <= 1'b0;
        end else begin
            {first_irq_pin_oe_n_out, first_irq_pin_out} <= pin_drive(first_active,
                pin_electrical_config[`AIC_BIT_P1_POL],
                pin_electrical_config[`AIC_BIT_P1_OD]);
            {second_irq_pin_oe_n_out, second_irq_pin_out} <= pin_drive(second_active,
                pin_electrical_config[`AIC_BIT_P2_POL],
                pin_electrical_config[`AIC_BIT_P2_OD]);
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            engine_unfiltered_out <= 6'h00;
            weak_accel_sum_mode_out <= 1'b0;
        end else begin
            engine_unfiltered_out <= engine_source_select[5:0];
            weak_accel_sum_mode_out <= lowg_highg_hysteresis[`AIC_BIT_LOW_MODE];
        end
    end

    // Scaled thresholds for the comparator datapath
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            weak_accel_threshold_cmg_out <= 18'h00000;
            weak_accel_hysteresis_mg_out <= 9'h000;
            strong_accel_hysteresis_mg_out <= 12'h000;
        end else begin
            weak_accel_threshold_cmg_out <= 18'(lowg_threshold) * `AIC_LOWTH_STEP_CMG;
            weak_accel_hysteresis_mg_out <= 9'(12'(lowg_highg_hysteresis[1:0]) *
                `AIC_LOWHY_STEP_MG);
            unique case (range_sel_in)
                2'h0: strong_accel_hysteresis_mg_out <= 12'(lowg_highg_hysteresis[7:6]) *
                    `AIC_HIGHHY_STEP_2G_MG;
                2'h1: strong_accel_hysteresis_mg_out <= 12'(lowg_highg_hysteresis[7:6]) *
                    `AIC_HIGHHY_STEP_4G_MG;
                2'h2: strong_accel_hysteresis_mg_out <= 12'(lowg_highg_hysteresis[7:6]) *
                    `AIC_HIGHHY_STEP_8G_MG;
                2'h3: strong_accel_hysteresis_mg_out <= 12'(lowg_highg_hysteresis[7:6]) *
                    `AIC_HIGHHY_STEP_16G_MG;
            endcase
        end
    end
endmodule

`default_nettype wire

//--- dv/aic_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module aic_top_asserts #(
    parameter int BASE_TICK_CYC = 4
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic [7:2] engine_event_in,
    input wire logic weak_accel_cond_in,
    input wire logic strong_accel_cond_in,
    input wire logic [7:0] first_pin_route_in,
    input wire logic [1:0] range_sel_in,
    input wire logic [5:0] engine_unfiltered_out,
    input wire logic [17:0] weak_accel_threshold_cmg_out,
    input wire logic [8:0] weak_accel_hysteresis_mg_out,
    input wire logic [11:0] strong_accel_hysteresis_mg_out,
    input wire logic weak_accel_sum_mode_out,
    input wire logic [7:0] engine_status_out,
    input wire logic first_irq_pin_out,
    input wire logic first_irq_pin_oe_n_out,
    input wire logic second_irq_pin_out,
    input wire logic second_irq_pin_oe_n_out
);
    logic [7:0] pcfg, route2, ldly, hdly;
    logic [3:0] hold;
    logic [15:0] lcnt, hcnt;
    logic [31:0] llo, lhi, hlo, hhi;
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pcfg <= 8'h05;
            route2 <= 8'h00;
            ldly <= 8'h09;
            hdly <= 8'h0F;
            hold <= 4'h0;
        end else if (reg_wr_in) begin
            if (reg_addr_in == 8'h20) pcfg <= reg_wdata_in & 8'h0F;
            if (reg_addr_in == 8'h1B) route2 <= reg_wdata_in;
            if (reg_addr_in == 8'h22) ldly <= reg_wdata_in;
            if (reg_addr_in == 8'h25) hdly <= reg_wdata_in;
            if (reg_addr_in == 8'h21) hold <= reg_wdata_in[3:0];
        end
    end
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            lcnt <= 16'h0000;
            hcnt <= 16'h0000;
        end else begin
            lcnt <= weak_accel_cond_in ? lcnt + 16'h0001 : 16'h0000;
            hcnt <= strong_accel_cond_in ? hcnt + 16'h0001 : 16'h0000;
        end
    end
    assign llo = ({24'h0, ldly} + 32'h1) * 8 * BASE_TICK_CYC;
    assign lhi = llo + 8 * BASE_TICK_CYC + 6;
    assign hlo = ({24'h0, hdly} + 32'h1) * 8 * BASE_TICK_CYC;
    assign hhi = hlo + 8 * BASE_TICK_CYC + 6;
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);
    a_unfilt_copy: assert property (
        reg_rd_in && reg_addr_in == 8'h1E |=> reg_rdata_out[5:0] == engine_unfiltered_out
    ) else $error("source select copy wrong");
    a_lowth_scale: assert property (
        reg_rd_in && reg_addr_in == 8'h23 |=>
        weak_accel_threshold_cmg_out == reg_rdata_out * 18'd781
    ) else $error("weak threshold wrong");
    a_lowhy_mode: assert property (
        reg_rd_in && reg_addr_in == 8'h24 |=>
        weak_accel_hysteresis_mg_out == reg_rdata_out[1:0] * 9'd125
        && weak_accel_sum_mode_out == reg_rdata_out[2]
    ) else $error("weak hysteresis wrong");
    a_highhy_range: assert property (
        reg_rd_in && reg_addr_in == 8'h24 |=>
        strong_accel_hysteresis_mg_out == (12'd125 << range_sel_in) * reg_rdata_out[7:6]
    ) else $error("strong hysteresis wrong");
    a_clear_reads_zero: assert property (
        reg_rd_in && reg_addr_in == 8'h21 |=> reg_rdata_out[7:4] == 4'h0
    ) else $error("clear bit read back");
    a_clear_drops: assert property (
        reg_wr_in && reg_addr_in == 8'h21 && reg_wdata_in[7] && engine_event_in == 6'h00
        |=> ##[0:1] engine_status_out[7:2] == 6'h00
    ) else $error("clear ignored");
    a_latch_keeps: assert property (
        hold[2:0] == 3'h7 && engine_status_out[7] && !(reg_wr_in && reg_addr_in == 8'h21)
        && !$past(reg_wr_in && reg_addr_in == 8'h21) |=> engine_status_out[7]
    ) else $error("latched interrupt dropped");
    a_nolatch_drop: assert property (
        hold[2:0] == 3'h0 && $fell(engine_event_in[7]) |-> ##[1:2] !engine_status_out[7]
    ) else $error("non-latched interrupt held");
    a_lowg_delay: assert property (
        $rose(engine_status_out[0]) |-> {16'h0, lcnt} >= llo && {16'h0, lcnt} <= lhi
    ) else $error("weak delay wrong");
    a_highg_delay: assert property (
        $rose(engine_status_out[1]) |-> {16'h0, hcnt} >= hlo && {16'h0, hcnt} <= hhi
    ) else $error("strong delay wrong");
    a_pin1_follow: assert property (
        first_irq_pin_out == (|(engine_status_out & $past(first_pin_route_in)) ~^ $past(pcfg[0]))
        && first_irq_pin_oe_n_out == (first_irq_pin_out & $past(pcfg[1]))
    ) else $error("pin1 wrong");
    a_pin2_follow: assert property (
        second_irq_pin_out == (|(engine_status_out & $past(route2)) ~^ $past(pcfg[2]))
        && second_irq_pin_oe_n_out == (second_irq_pin_out & $past(pcfg[3]))
    ) else $error("pin2 wrong");
    c_latch_clear: cover property (reg_wr_in && reg_addr_in == 8'h21 && reg_wdata_in[7]
        && engine_status_out[7]);
    c_lowg_fire: cover property ($rose(engine_status_out[0]));
    c_od_release: cover property (second_irq_pin_oe_n_out);
endmodule
bind aic_top aic_top_asserts #(.BASE_TICK_CYC(BASE_TICK_CYC)) u_asserts (
    .core_clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .engine_event_in, .weak_accel_cond_in, .strong_accel_cond_in,
    .first_pin_route_in, .range_sel_in, .engine_unfiltered_out, .weak_accel_threshold_cmg_out,
    .weak_accel_hysteresis_mg_out, .strong_accel_hysteresis_mg_out, .weak_accel_sum_mode_out,
    .engine_status_out, .first_irq_pin_out, .first_irq_pin_oe_n_out, .second_irq_pin_out,
    .second_irq_pin_oe_n_out
);
`default_nettype wire

//--- dv/aic_host_mon.sv
`timescale 1ns/1ps
`default_nettype none
module aic_host_mon (
    input wire logic pin_in,
    input wire logic oe_n_in,
    output logic level_out
);
    assign level_out = oe_n_in ? 1'b1 : pin_in;
endmodule
`default_nettype wire

//--- dv/tb_aic_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_aic_top;
    localparam int BT = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:2] ev = 6'h00;
    logic wcond = 1'b0;
    logic scond = 1'b0;
    logic [7:0] r1 = 8'h00;
    logic [1:0] rng = 2'h0;
    logic [7:0] rdata, st;
    logic [5:0] unf;
    logic [17:0] lth;
    logic [8:0] lhy;
    logic [11:0] hhy;
    logic mode, p1, oe1, p2, oe2, lv1, lv2;
    logic [7:0] ra [9] = '{8'h1B, 8'h1E, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h1C};
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    always #10 clk = ~clk;
    aic_top #(.BASE_TICK_CYC(BT)) dut (
        .core_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .engine_event_in(ev),
        .weak_accel_cond_in(wcond), .strong_accel_cond_in(scond), .first_pin_route_in(r1),
        .range_sel_in(rng), .engine_unfiltered_out(unf), .weak_accel_threshold_cmg_out(lth),
        .weak_accel_hysteresis_mg_out(lhy), .strong_accel_hysteresis_mg_out(hhy),
        .weak_accel_sum_mode_out(mode), .engine_status_out(st), .first_irq_pin_out(p1),
        .first_irq_pin_oe_n_out(oe1), .second_irq_pin_out(p2), .second_irq_pin_oe_n_out(oe2)
    );
    aic_host_mon host1 (.pin_in(p1), .oe_n_in(oe1), .level_out(lv1));
    aic_host_mon host2 (.pin_in(p2), .oe_n_in(oe2), .level_out(lv2));
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic chk_pins(input logic a1, input logic a2, input logic [3:0] c);
        check("p1", {oe1, p1, lv1}, {c[1] & (a1 ~^ c[0]), {2{a1 ~^ c[0]}}});
        check("p2", {oe2, p2, lv2}, {c[3] & (a2 ~^ c[2]), {2{a2 ~^ c[2]}}});
    endtask
    task automatic t_reset();
        logic [7:0] d;
        logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h05, 8'h00, 8'h09, 8'h30, 8'h81, 8'h0F, 8'h00};
        tick(2);
        chk_pins(1'b0, 1'b0, 4'h5);
        check("low thr", lth, 32'd37488);
        check("hyst", {hhy, lhy, mode}, {12'd250, 9'd125, 1'b0});
        foreach (ra[i]) begin
            rd_reg(ra[i], d);
            check("reset", d, rv[i]);
        end
    endtask
    task automatic t_rw();
        logic [7:0] d;
        logic [7:0] mk [9] = '{8'hFF, 8'h3F, 8'h0F, 8'h0F, 8'hFF, 8'hFF, 8'hC7, 8'hFF, 8'h00};
        logic [7:0] pv [2] = '{8'hFF, 8'h00};
        foreach (pv[j]) begin
            foreach (ra[i]) wr_reg(ra[i], pv[j]);
            foreach (ra[i]) begin
                rd_reg(ra[i], d);
                check("readback", d, pv[j] & mk[i]);
            end
            check("unfiltered", unf, pv[j][5:0]);
            check("low thr", lth, pv[j] * 18'd781);
            for (int r = 0; r < 4; r++) begin
                @(posedge clk);
                rng <= 2'(r);
                tick(2);
                check("hyst", {hhy, lhy, mode},
                    {(12'd125 << r) * pv[j][7:6], 9'd125 * pv[j][1:0], pv[j][2]});
            end
        end
    endtask
    task automatic t_route();
        for (int k = 2; k < 8; k++) begin
            wr_reg(8'h1B, 8'h01 << k);
            @(posedge clk);
            r1 <= 8'h01 << k;
            ev <= ~(6'h01 << (k - 2));
            tick(4);
            chk_pins(1'b0, 1'b0, 4'h5);
            @(posedge clk);
            ev <= 6'h01 << (k - 2);
            tick(4);
            chk_pins(1'b1, 1'b1, 4'h5);
        end
        @(posedge clk);
        ev <= 6'h00;
    endtask
    task automatic t_pins();
        for (int c = 0; c < 4; c++) begin
            wr_reg(8'h20, {4'h0, {2{2'(c)}}});
            tick(3);
            chk_pins(1'b0, 1'b0, {2{2'(c)}});
            @(posedge clk);
            ev[7] <= 1'b1;
            tick(3);
            chk_pins(1'b1, 1'b1, {2{2'(c)}});
            @(posedge clk);
            ev[7] <= 1'b0;
        end
        wr_reg(8'h20, 8'h05);
    endtask
    task automatic t_hold(input logic [3:0] cd, input int tk);
        wr_reg(8'h21, {4'h0, cd});
        @(posedge clk);
        ev[7] <= 1'b1;
        @(posedge clk);
        ev[7] <= 1'b0;
        if (tk == 0) begin
            tick(3);
            chk_pins(1'b0, 1'b0, 4'h5);
        end else begin
            tick(tk * BT - 1);
            chk_pins(1'b1, 1'b1, 4'h5);
            tick(BT + 5);
            chk_pins(1'b0, 1'b0, 4'h5);
        end
    endtask
    task automatic t_latch(input logic [3:0] cd);
        wr_reg(8'h21, {4'h0, cd});
        @(posedge clk);
        ev[7] <= 1'b1;
        @(posedge clk);
        ev[7] <= 1'b0;
        tick(900);
        chk_pins(1'b1, 1'b1, 4'h5);
        check("status", st, 8'h80);
        wr_reg(8'h21, {4'h0, cd});
        tick(3);
        chk_pins(1'b1, 1'b1, 4'h5);
        wr_reg(8'h21, {4'h8, cd});
        tick(3);
        chk_pins(1'b0, 1'b0, 4'h5);
    endtask
    task automatic t_delay(input logic hi, input int lo_c, input int hi_c);
        int n;
        n = 0;
        wr_reg(8'h21, 8'h00);
        wr_reg(8'h1B, 8'h03);
        @(posedge clk);
        wcond <= ~hi;
        scond <= hi;
        do begin
            tick(1);
            n++;
        end while (lv2 !== 1'b1 && n < 300);
        check("delay", (n >= lo_c && n <= hi_c), 1'b1);
        @(posedge clk);
        wcond <= 1'b0;
        scond <= 1'b0;
        tick(4);
        check("drop", lv2, 1'b0);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_rw();
        wr_reg(8'h20, 8'h05);
        t_route();
        t_pins();
        t_hold(4'h0, 0);
        t_hold(4'h8, 0);
        t_hold(4'h9, 1);
        t_hold(4'hA, 2);
        t_hold(4'hB, 4);
        t_hold(4'hC, 50);
        t_hold(4'hD, 100);
        t_hold(4'hE, 200);
        t_hold(4'h1, 1000);
        t_latch(4'h7);
        t_latch(4'hF);
        r1 <= 8'h00;
        t_delay(1'b0, 32, 70);
        wr_reg(8'h25, 8'h01);
        t_delay(1'b1, 64, 102);
        finish_test();
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            finish_test();
        end
    end
endmodule
`default_nettype wire
